// File: common/bcc_defines.svh
`ifndef BCC_DEFINES_SVH
`define BCC_DEFINES_SVH

// source select encodings
`define BCC_SRC_LSI        2'h0
`define BCC_SRC_XTAL       2'h1
`define BCC_SRC_PLL        2'h2

// pll reference divider and nominal ticks per second
`define BCC_PLL_DIV        128
`define BCC_NOMINAL_HZ     32768

// calibration sign encodings
`define BCC_CAL_PLUS       1'b0
`define BCC_CAL_MINUS      1'b1

// time word field positions
`define BCC_SEC_LSB        0
`define BCC_MIN_LSB        8
`define BCC_HOUR_LSB       16
`define BCC_WEEK_LSB       24

// calendar word field positions
`define BCC_DATE_LSB       0
`define BCC_MONTH_LSB      8
`define BCC_YEAR_LSB       16
`define BCC_CENT_LSB       24

// irq flag layout: alarm per field 7:0, all-alarm 8, rollover 16:9
`define BCC_FIELDS         8
`define BCC_IRQ_ALL        8
`define BCC_IRQ_ROLL_LSB   9
`define BCC_IRQ_W          17

// reset values
`define BCC_RST_TIME       32'h0000_0000
`define BCC_RST_CAL        32'h0000_0000

// bcd limits
`define BCC_SEC_LAST       8'h59
`define BCC_MIN_LAST       8'h59
`define BCC_HOUR_LAST      8'h23
`define BCC_WEEK_LAST      8'h07
`define BCC_WEEK_FIRST     8'h01
`define BCC_DATE_FIRST     8'h01
`define BCC_MONTH_LAST     8'h12
`define BCC_MONTH_FIRST    8'h01
`define BCC_YEAR_LAST      8'h99
`define BCC_ZERO           8'h00

`endif

// File: common/bcc_if.sv
`timescale 1ns/1ps
`default_nettype none

interface bcc_if #(
  parameter int CAL_W = 8
);
  logic [1:0]       src_sel;
  logic [6:0]       prescale;
  logic [7:0]       scale;
  logic             cal_active;
  logic             cal_sign;
  logic [CAL_W-1:0] cal_val;
  logic             cnt_clear;
  logic             cnt_hold;
  logic             src_xtal;
  logic             src_lsi;
  logic             src_pll;
  logic             sec_tick;

  modport core (
    output src_sel, prescale, scale, cal_active, cal_sign, cal_val,
    output cnt_clear, cnt_hold, src_xtal, src_lsi, src_pll,
    input  sec_tick
  );

  modport tick (
    input  src_sel, prescale, scale, cal_active, cal_sign, cal_val,
    input  cnt_clear, cnt_hold, src_xtal, src_lsi, src_pll,
    output sec_tick
  );
endinterface

`default_nettype wire

// File: common/bcc_pkg.sv
package bcc_pkg;

  typedef logic [7:0] bcc_bcd_t;
  typedef logic [8:0] bcc_step_t;

  typedef enum logic [2:0] {
    BCC_F_SEC   = 3'h0,
    BCC_F_MIN   = 3'h1,
    BCC_F_HOUR  = 3'h2,
    BCC_F_WEEK  = 3'h3,
    BCC_F_DATE  = 3'h4,
    BCC_F_MONTH = 3'h5,
    BCC_F_YEAR  = 3'h6,
    BCC_F_CENT  = 3'h7
  } bcc_field_t;

endpackage

// File: hw/bcc_tick.sv
`timescale 1ns/1ps
`default_nettype none
`include "bcc_defines.svh"

module bcc_tick
  import bcc_pkg::*;
#(
  parameter int CAL_W = 8
) (
  input  wire logic clk,
  input  wire logic rst,
  bcc_if.tick       tk
);

  logic [2:0]  src_q_r;
  logic [6:0]  pll_div_r;
  logic        pll_pulse;
  logic        src_pulse;
  logic [7:0]  ps1;
  logic [8:0]  sc1;
  logic [16:0] base;
  logic [16:0] cal17;
  logic [16:0] target;
  logic [16:0] cnt_r;
  logic        sec_r;

  // source levels are sampled at clk; count their rising edges
  always_ff @(posedge clk) begin
    if (rst) begin
      src_q_r <= 3'h0;
    end else begin
      src_q_r <= {tk.src_pll, tk.src_lsi, tk.src_xtal};
    end
  end

  always_ff @(posedge clk) begin
    if (rst || tk.cnt_clear) begin
      pll_div_r <= 7'h00;
    end else if (tk.src_pll && !src_q_r[2]) begin
      pll_div_r <= pll_div_r + 7'h01;
    end
  end

  assign pll_pulse = tk.src_pll && !src_q_r[2] && (pll_div_r == 7'(`BCC_PLL_DIV - 1));

  always_comb begin
    case (tk.src_sel)
      `BCC_SRC_XTAL: src_pulse = tk.src_xtal && !src_q_r[0];
      `BCC_SRC_LSI:  src_pulse = tk.src_lsi && !src_q_r[1];
      `BCC_SRC_PLL:  src_pulse = pll_pulse;
      default:       src_pulse = 1'b0;
    endcase
  end

  assign ps1   = {1'b0, tk.prescale} + 8'h01;
  assign sc1   = {1'b0, tk.scale} + 9'h001;
  assign base  = 17'({9'h000, ps1}) * 17'({8'h00, sc1});
  assign cal17 = 17'({{(17 - CAL_W){1'b0}}, tk.cal_val});

  // minus side clamps at one tick so a bad setting cannot stall the clock
  always_comb begin
    if (!tk.cal_active) begin
      target = base;
    end else if (tk.cal_sign == `BCC_CAL_PLUS) begin
      target = base + cal17;
    end else if (cal17 >= base) begin
      target = 17'h00001;
    end else begin
      target = base - cal17;
    end
  end

  // value is read live at every source pulse, so a mid-second tweak takes effect in the current period
  always_ff @(posedge clk) begin
    if (rst || tk.cnt_clear) begin
      cnt_r <= 17'h00000;
      sec_r <= 1'b0;
    end else begin
      sec_r <= 1'b0;
      if (src_pulse && !tk.cnt_hold) begin
        if (cnt_r >= target - 17'h00001) begin
          cnt_r <= 17'h00000;
          sec_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 17'h00001;
        end
      end
    end
  end

  assign tk.sec_tick = sec_r;

endmodule // bcc_tick

`default_nettype wire

// File: hw/bcc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "bcc_defines.svh"

// Behaviour
// - seconds come from crystal, internal low speed oscillator, or pll reference over 128.
// - hour, minute, second, century, year, month, week, day all held in bcd.
// - february gets 29 days in leap years with no software help.
// - each of the eight counters flags its own rollover event.
// - any enabled event raises a wake-up toward the low-power controller.
// - enable, reset, prescale, scale, calibration value and sign are control inputs.
// - prescale 0x7f and scale 0xff give one second per 32768 source ticks.
// - halt bit set freezes counting while time and calendar are written; clear resumes.
// - count enable 1 runs the clock; source select 1 picks the crystal.
// - compensation applies only when calibration enable and cycle select are both 1.
// - per-second count is nominal plus value for sign 0, minus for sign 1.
// - day of week runs 1 to 7, monday to sunday.
// - matching enabled alarm fields set raw alarm flags 8:0 and request interrupt when enabled in irq_enable_set.
// - periodic alarm compares only fields chosen by the field enable.
// - all-alarm fires only when all enables set and every field matches.
// - alarm words pack calendar and time as bcd bytes.
// - time word holds week 26:24, hours 21:16, minutes 14:8, seconds 6:0.
// - status shows unmasked occurred events; writing 1 clears the flag.
module bcc_top
  import bcc_pkg::*;
#(
  parameter int CAL_W = 8
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  clock_reset,
  input  wire logic                  count_enable,
  input  wire logic                  halt_update,
  input  wire logic [1:0]            source_select,
  input  wire logic [6:0]            prescale_value,
  input  wire logic [7:0]            scale_value,
  input  wire logic                  calibration_sign,
  input  wire logic [CAL_W-1:0]      calibration_value,
  input  wire logic                  calibration_enable,
  input  wire logic                  cycle_select,
  input  wire logic                  xtal_clk,
  input  wire logic                  internal_low_speed_osc,
  input  wire logic                  pll_ref_clk,
  input  wire logic                  time_wr,
  input  wire logic [31:0]           time_wdata,
  input  wire logic                  cal_wr,
  input  wire logic [31:0]           cal_wdata,
  input  wire logic [31:0]           alarm_time,
  input  wire logic [31:0]           alarm_calendar,
  input  wire logic [7:0]            alarm_field_enable,
  input  wire logic [`BCC_IRQ_W-1:0] irq_enable_set,
  input  wire logic [`BCC_IRQ_W-1:0] irq_clear,
  output logic      [31:0]           time_value,
  output logic      [31:0]           calendar_value,
  output logic      [`BCC_IRQ_W-1:0] raw_irq_flags,
  output logic      [`BCC_IRQ_W-1:0] irq_status,
  output logic                       irq_req,
  output logic                       wake_up,
  output logic                       second_tick
);

  bcc_if #(.CAL_W(CAL_W)) tif ();

  logic [6:0]  sec_r;
  logic [6:0]  min_r;
  logic [5:0]  hour_r;
  logic [2:0]  week_r;
  logic [5:0]  date_r;
  logic [4:0]  month_r;
  logic [7:0]  year_r;
  logic [7:0]  cent_r;

  logic        advance;
  bcc_step_t   st_sec;
  bcc_step_t   st_min;
  bcc_step_t   st_hour;
  bcc_step_t   st_week;
  bcc_step_t   st_date;
  bcc_step_t   st_month;
  bcc_step_t   st_year;
  bcc_step_t   st_cent;
  bcc_bcd_t    date_last;
  logic [7:0]  roll_ev;

  bcc_bcd_t    cur_f [`BCC_FIELDS];
  bcc_bcd_t    alm_f [`BCC_FIELDS];
  logic [7:0]  field_eq;
  logic [7:0]  match;
  logic [7:0]  match_q_r;
  logic [7:0]  alm_ev;
  logic        all_match;
  logic        all_q_r;
  logic        all_ev;

  logic [`BCC_IRQ_W-1:0] events;
  logic [`BCC_IRQ_W-1:0] raw_r;
  logic [`BCC_IRQ_W-1:0] raw_nxt;
  logic [`BCC_IRQ_W-1:0] status_r;
  logic                  irq_r;
  logic                  wake_r;
  logic                  tick_r;

  // one bcd step: returns {wrap, next}; values at or past the limit wrap too
  function automatic bcc_step_t bcd_step(input bcc_bcd_t v, input bcc_bcd_t last, input bcc_bcd_t first);
    if (v >= last) begin
      bcd_step = {1'b1, first};
    end else if (v[3:0] == 4'h9) begin
      bcd_step = {1'b0, 4'(v[7:4] + 4'h1), 4'h0};
    end else begin
      bcd_step = {1'b0, v[7:4], 4'(v[3:0] + 4'h1)};
    end
  endfunction

  // bcd byte divisible by four: ten is two mod four
  function automatic logic bcd_div4(input bcc_bcd_t b);
    logic [4:0] s;
    s = {b[7:4], 1'b0} + {1'b0, b[3:0]};
    bcd_div4 = (s[1:0] == 2'h0);
  endfunction

  function automatic bcc_bcd_t month_days(input bcc_bcd_t m, input bcc_bcd_t y, input bcc_bcd_t c);
    logic leap;
    leap = bcd_div4(y) && ((y != `BCC_ZERO) || bcd_div4(c));
    case (m)
      8'h02:   month_days = leap ? 8'h29 : 8'h28;
      8'h04,
      8'h06,
      8'h09,
      8'h11:   month_days = 8'h30;
      default: month_days = 8'h31;
    endcase
  endfunction

  // configuration toward the second prescaler
  assign tif.src_sel    = source_select;
  assign tif.prescale   = prescale_value;
  assign tif.scale      = scale_value;
  assign tif.cal_active = calibration_enable && cycle_select;
  assign tif.cal_sign   = calibration_sign;
  assign tif.cal_val    = calibration_value;
  assign tif.cnt_clear  = clock_reset || !count_enable;
  assign tif.cnt_hold   = halt_update;
  assign tif.src_xtal   = xtal_clk;
  assign tif.src_lsi    = internal_low_speed_osc;
  assign tif.src_pll    = pll_ref_clk;

  bcc_tick #(
    .CAL_W (CAL_W)
  ) u_tick (
    .clk (clk),
    .rst (rst),
    .tk  (tif.tick)
  );

  // writes land even without halt, but halt keeps a tick from racing them
  assign advance = tif.sec_tick && count_enable && !halt_update && !clock_reset && !time_wr;

  assign date_last = month_days({3'h0, month_r}, year_r, cent_r);
  assign st_sec    = bcd_step({1'b0, sec_r}, `BCC_SEC_LAST, `BCC_ZERO);
  assign st_min    = bcd_step({1'b0, min_r}, `BCC_MIN_LAST, `BCC_ZERO);
  assign st_hour   = bcd_step({2'h0, hour_r}, `BCC_HOUR_LAST, `BCC_ZERO);
  assign st_week   = bcd_step({5'h00, week_r}, `BCC_WEEK_LAST, `BCC_WEEK_FIRST);
  assign st_date   = bcd_step({2'h0, date_r}, date_last, `BCC_DATE_FIRST);
  assign st_month  = bcd_step({3'h0, month_r}, `BCC_MONTH_LAST, `BCC_MONTH_FIRST);
  assign st_year   = bcd_step(year_r, `BCC_YEAR_LAST, `BCC_ZERO);
  assign st_cent   = bcd_step(cent_r, `BCC_YEAR_LAST, `BCC_ZERO);

  assign roll_ev[BCC_F_SEC]   = advance && st_sec[8];
  assign roll_ev[BCC_F_MIN]   = roll_ev[BCC_F_SEC] && st_min[8];
  assign roll_ev[BCC_F_HOUR]  = roll_ev[BCC_F_MIN] && st_hour[8];
  assign roll_ev[BCC_F_WEEK]  = roll_ev[BCC_F_HOUR] && st_week[8];
  assign roll_ev[BCC_F_DATE]  = roll_ev[BCC_F_HOUR] && st_date[8];
  assign roll_ev[BCC_F_MONTH] = roll_ev[BCC_F_DATE] && st_month[8];
  assign roll_ev[BCC_F_YEAR]  = roll_ev[BCC_F_MONTH] && st_year[8];
  assign roll_ev[BCC_F_CENT]  = roll_ev[BCC_F_YEAR] && st_cent[8];

  // time word
  always_ff @(posedge clk) begin
    if (rst || clock_reset) begin
      sec_r  <= 7'h00;
      min_r  <= 7'h00;
      hour_r <= 6'h00;
      week_r <= 3'h0;
    end else if (time_wr) begin
      sec_r  <= time_wdata[`BCC_SEC_LSB +: 7];
      min_r  <= time_wdata[`BCC_MIN_LSB +: 7];
      hour_r <= time_wdata[`BCC_HOUR_LSB +: 6];
      week_r <= time_wdata[`BCC_WEEK_LSB +: 3];
    end else begin
      if (advance) begin
        sec_r <= st_sec[6:0];
      end
      if (roll_ev[BCC_F_SEC]) begin
        min_r <= st_min[6:0];
      end
      if (roll_ev[BCC_F_MIN]) begin
        hour_r <= st_hour[5:0];
      end
      if (roll_ev[BCC_F_HOUR]) begin
        week_r <= st_week[2:0];
      end
    end
  end

  // calendar word
  always_ff @(posedge clk) begin
    if (rst || clock_reset) begin
      date_r  <= 6'h00;
      month_r <= 5'h00;
      year_r  <= 8'h00;
      cent_r  <= 8'h00;
    end else if (cal_wr) begin
      date_r  <= cal_wdata[`BCC_DATE_LSB +: 6];
      month_r <= cal_wdata[`BCC_MONTH_LSB +: 5];
      year_r  <= cal_wdata[`BCC_YEAR_LSB +: 8];
      cent_r  <= cal_wdata[`BCC_CENT_LSB +: 8];
    end else begin
      if (roll_ev[BCC_F_HOUR]) begin
        date_r <= st_date[5:0];
      end
      if (roll_ev[BCC_F_DATE]) begin
        month_r <= st_month[4:0];
      end
      if (roll_ev[BCC_F_MONTH]) begin
        year_r <= st_year[7:0];
      end
      if (roll_ev[BCC_F_YEAR]) begin
        cent_r <= st_cent[7:0];
      end
    end
  end

  // current and alarm fields as bcd bytes, same order as the enable bits
  assign cur_f[BCC_F_SEC]   = {1'b0, sec_r};
  assign cur_f[BCC_F_MIN]   = {1'b0, min_r};
  assign cur_f[BCC_F_HOUR]  = {2'h0, hour_r};
  assign cur_f[BCC_F_WEEK]  = {5'h00, week_r};
  assign cur_f[BCC_F_DATE]  = {2'h0, date_r};
  assign cur_f[BCC_F_MONTH] = {3'h0, month_r};
  assign cur_f[BCC_F_YEAR]  = year_r;
  assign cur_f[BCC_F_CENT]  = cent_r;

  assign alm_f[BCC_F_SEC]   = {1'b0, alarm_time[`BCC_SEC_LSB +: 7]};
  assign alm_f[BCC_F_MIN]   = {1'b0, alarm_time[`BCC_MIN_LSB +: 7]};
  assign alm_f[BCC_F_HOUR]  = {2'h0, alarm_time[`BCC_HOUR_LSB +: 6]};
  assign alm_f[BCC_F_WEEK]  = {5'h00, alarm_time[`BCC_WEEK_LSB +: 3]};
  assign alm_f[BCC_F_DATE]  = {2'h0, alarm_calendar[`BCC_DATE_LSB +: 6]};
  assign alm_f[BCC_F_MONTH] = {3'h0, alarm_calendar[`BCC_MONTH_LSB +: 5]};
  assign alm_f[BCC_F_YEAR]  = alarm_calendar[`BCC_YEAR_LSB +: 8];
  assign alm_f[BCC_F_CENT]  = alarm_calendar[`BCC_CENT_LSB +: 8];

  // edge of the match so a minute alarm fires once at its :00, not every cycle
  for (genvar i = 0; i < `BCC_FIELDS; i++) begin : g_alarm
    assign field_eq[i] = (cur_f[i] == alm_f[i]);
    assign match[i]    = alarm_field_enable[i] && field_eq[i];
    assign alm_ev[i]   = match[i] && !match_q_r[i];
  end

  assign all_match = (&alarm_field_enable) && (&field_eq);
  assign all_ev    = all_match && !all_q_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      match_q_r <= 8'h00;
      all_q_r   <= 1'b0;
    end else begin
      match_q_r <= match;
      all_q_r   <= all_match;
    end
  end

  assign events = {roll_ev, all_ev, alm_ev};

  // a new event in the clearing cycle survives the clear
  assign raw_nxt = (raw_r & ~irq_clear) | events;

  always_ff @(posedge clk) begin
    if (rst) begin
      raw_r    <= `BCC_IRQ_W'(0);
      status_r <= `BCC_IRQ_W'(0);
      irq_r    <= 1'b0;
      wake_r   <= 1'b0;
      tick_r   <= 1'b0;
    end else begin
      raw_r    <= raw_nxt;
      status_r <= raw_nxt & irq_enable_set;
      irq_r    <= |(raw_nxt & irq_enable_set);
      wake_r   <= |(events & irq_enable_set);
      tick_r   <= advance;
    end
  end

  assign time_value = {5'h00, week_r, 2'h0, hour_r, 1'b0, min_r, 1'b0, sec_r};
  assign calendar_value = {cent_r, year_r, 3'h0, month_r, 2'h0, date_r};
  assign raw_irq_flags  = raw_r;
  assign irq_status     = status_r;
  assign irq_req        = irq_r;
  assign wake_up        = wake_r;
  assign second_tick    = tick_r;

endmodule // bcc_top

`default_nettype wire

// File: test/bcc_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "bcc_defines.svh"
module bcc_properties (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  clock_reset,
  input wire logic                  halt_update,
  input wire logic                  time_wr,
  input wire logic [31:0]           time_wdata,
  input wire logic                  cal_wr,
  input wire logic [31:0]           alarm_time,
  input wire logic [31:0]           alarm_calendar,
  input wire logic [7:0]            alarm_field_enable,
  input wire logic [`BCC_IRQ_W-1:0] irq_enable_set,
  input wire logic [`BCC_IRQ_W-1:0] irq_clear,
  input wire logic [31:0]           time_value,
  input wire logic [31:0]           calendar_value,
  input wire logic [`BCC_IRQ_W-1:0] raw_irq_flags,
  input wire logic [`BCC_IRQ_W-1:0] irq_status,
  input wire logic                  second_tick
);
  // reserved bits masked off
  localparam logic [31:0] TM = 32'h073f_7f7f;
  localparam logic [31:0] CM = 32'hffff_1f3f;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_time_load: assert property (
    time_wr && !clock_reset |=> (time_value & TM) == ($past(time_wdata) & TM)) else $error("time load lost");
  a_soft_reset: assert property (
    clock_reset && !time_wr && !cal_wr |=> time_value == 32'h0 && calendar_value == 32'h0)
    else $error("soft reset kept time");
  // four cycles so a source edge already in flight has drained
  a_halt_freeze: assert property (
    halt_update [*4] |-> !second_tick) else $error("second counted while halted");
  a_sec_step: assert property (
    second_tick && $past(!time_wr && !clock_reset && time_value[3:0] < 4'h9)
    |-> time_value[3:0] == $past(time_value[3:0]) + 4'h1) else $error("second units step wrong");
  a_sec_roll: assert property (
    second_tick && $past(!time_wr && !clock_reset && time_value[6:0] == 7'h59)
    |-> time_value[6:0] == 7'h0 && raw_irq_flags[9] && time_value[14:8] != $past(time_value[14:8]))
    else $error("second rollover wrong");
  a_week_roll: assert property (
    second_tick && $past(!time_wr && !clock_reset && time_value[21:0] == 22'h23_5959)
    |-> time_value[21:0] == 22'h0 && time_value[26:24] inside {[3'h1:3'h7]}) else $error("day change wrong");
  a_min_alarm: assert property (
    $rose(alarm_field_enable[1] && time_value[14:8] == alarm_time[14:8]) |=> raw_irq_flags[1])
    else $error("minute alarm missed");
  a_all_alarm: assert property (
    $rose(raw_irq_flags[`BCC_IRQ_ALL]) |-> $past(alarm_field_enable == 8'hff
    && (time_value & TM) == (alarm_time & TM) && (calendar_value & CM) == (alarm_calendar & CM)))
    else $error("all alarm without full match");
  a_status_mask: assert property (
    (irq_status & ~$past(irq_enable_set)) == '0) else $error("masked flag in status");
  a_roll_clear: assert property (
    irq_clear[9] |=> !raw_irq_flags[9] || second_tick) else $error("flag not cleared");
  c_second: cover property (second_tick);
  c_all_alarm: cover property ($rose(raw_irq_flags[`BCC_IRQ_ALL]));
  c_sec_roll: cover property ($rose(raw_irq_flags[9]));
endmodule // bcc_properties

bind bcc_top bcc_properties bcc_properties_inst (.*);
`default_nettype wire

// File: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "bcc_defines.svh"
module tb;
  logic        clk = 0, rst = 1, clock_reset = 0, count_enable = 1, halt_update = 0;
  logic        calibration_sign = 0, calibration_enable = 0, cycle_select = 1;
  logic        xtal_clk = 0, internal_low_speed_osc = 0, pll_ref_clk = 0, time_wr = 0, cal_wr = 0;
  logic        irq_req, wake_up, second_tick;
  logic [1:0]  source_select = 2'h1;
  logic [6:0]  prescale_value = 7'h0;
  logic [7:0]  scale_value = 8'h0, calibration_value = 8'h0, alarm_field_enable = 8'h0;
  logic [16:0] irq_enable_set = '0, irq_clear = '0, raw_irq_flags, irq_status;
  logic [31:0] time_wdata = '0, cal_wdata = '0, alarm_time = '0, alarm_calendar = '0;
  logic [31:0] time_value, calendar_value;
  int          fails = 0, n_tests = 0, n_sec = 0, n_wake = 0;
  localparam logic [31:0] CIN [5] = '{32'h2024_0228, 32'h2023_0228, 32'h2100_0228, 32'h2000_0228, 32'h9999_1231};
  localparam logic [31:0] CEX [5] = '{32'h2024_0229, 32'h2023_0301, 32'h2100_0301, 32'h2000_0229, 32'h0000_0101};
  localparam logic [16:0] REX [5] = '{17'h01e00, 17'h03e00, 17'h03e00, 17'h01e00, 17'h1fe00};

  bcc_top bcc_top_inst (.*);

  initial forever #2.5 clk = ~clk;

  always @(posedge clk) begin
    if (second_tick === 1'b1) n_sec <= n_sec + 1;
    if (wake_up === 1'b1) n_wake <= n_wake + 1;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic src(input int k);
    repeat (k) begin
      @(negedge clk);
      internal_low_speed_osc = (source_select == 2'h0);
      xtal_clk = (source_select == 2'h1);
      pll_ref_clk = (source_select == 2'h2);
      @(negedge clk);
      {xtal_clk, internal_low_speed_osc, pll_ref_clk} = 3'h0;
    end
    cyc(4);
  endtask

  task automatic wr(input logic [31:0] t, input logic [31:0] c);
    @(negedge clk);
    time_wr = 1;
    time_wdata = t;
    cal_wr = 1;
    cal_wdata = c;
    @(negedge clk);
    time_wr = 0;
    cal_wr = 0;
  endtask

  task automatic clr;
    @(negedge clk);
    irq_clear = '1;
    @(negedge clk);
    irq_clear = '0;
    cyc(1);
  endtask

  // count_enable low clears the prescaler so each run starts from zero
  task automatic sec_len(input int n);
    int c;
    cyc(1);
    count_enable = 0;
    cyc(1);
    count_enable = 1;
    c = n_sec;
    src(n - 1);
    chk(n_sec, c);
    src(1);
    chk(n_sec, c + 1);
  endtask

  task automatic t_load;
    halt_update = 1;
    wr(32'h0617_3000, 32'h2015_0808);
    chk(time_value, 32'h0617_3000);
    chk(calendar_value, 32'h2015_0808);
    src(3);
    chk(time_value, 32'h0617_3000);
    halt_update = 0;
    src(1);
    chk(time_value, 32'h0617_3001);
    clock_reset = 1;
    cyc(1);
    clock_reset = 0;
    cyc(1);
    chk(time_value | calendar_value, 32'h0);
  endtask

  task automatic t_src;
    source_select = 2'h0;
    sec_len(1);
    source_select = 2'h2;
    sec_len(128);
    source_select = 2'h1;
    prescale_value = 7'h7f;
    scale_value = 8'hff;
    sec_len(32768);
    prescale_value = 7'h7;
    scale_value = 8'h0;
    calibration_enable = 1;
    calibration_value = 8'h5;
    sec_len(13);
    calibration_value = 8'h2c;
    sec_len(52);
    calibration_value = 8'h5;
    sec_len(13);
    calibration_sign = 1;
    calibration_value = 8'h3;
    sec_len(5);
    cycle_select = 0;
    sec_len(8);
    calibration_enable = 0;
    prescale_value = 7'h0;
  endtask

  task automatic t_roll;
    for (int i = 0; i < 5; i++) begin
      clr();
      wr(32'h0723_5959, CIN[i]);
      src(1);
      chk(time_value, 32'h0100_0000);
      chk(calendar_value, CEX[i]);
      chk(32'(raw_irq_flags & 17'h1fe00), 32'(REX[i]));
    end
    clr();
    chk(32'(raw_irq_flags), 32'h0);
  endtask

  task automatic t_alarm;
    int w;
    alarm_time = 32'h0000_5000;
    alarm_field_enable = 8'h02;
    irq_enable_set = 17'h00002;
    wr(32'h0112_4959, 32'h2015_0808);
    clr();
    w = n_wake;
    src(1);
    chk(32'(raw_irq_flags & 17'h001ff), 32'h2);
    chk(32'(irq_status), 32'h2);
    chk(32'(irq_req), 32'h1);
    chk(32'(n_wake > w), 32'h1);
    irq_enable_set = '0;
    cyc(2);
    chk(32'({irq_req, irq_status, raw_irq_flags[1]}), 32'h1);
    clr();
    chk(32'(raw_irq_flags[1]), 32'h0);
  endtask

  task automatic t_all;
    alarm_time = 32'h0617_3000;
    alarm_calendar = 32'h2015_0808;
    alarm_field_enable = 8'hff;
    irq_enable_set = 17'h00100;
    wr(32'h0617_2959, 32'h2015_0807);
    clr();
    src(1);
    chk(32'(raw_irq_flags[8]), 32'h0);
    wr(32'h0617_2959, 32'h2015_0808);
    clr();
    src(1);
    chk(32'(raw_irq_flags[8]), 32'h1);
    chk(32'(irq_req), 32'h1);
  endtask

  // hang guard
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    $display("Error at %0t: timeout", $time);
    complete_run();
  end

  initial begin
    repeat (6) @(negedge clk);
    rst = 0;
    cyc(1);
    chk(time_value | calendar_value | 32'(raw_irq_flags), 32'h0);
    t_load();
    t_src();
    t_roll();
    t_alarm();
    t_all();
    complete_run();
  end
endmodule // tb
`default_nettype wire
